// ===== core/can_rx_acceptance_filter.sv
// Receive acceptance filters, masks and the two receive buffers.
// Assumes the assembled frame and register port come from logic on the same clock.
`timescale 1ns/10ps
module can_rx_acceptance_filter #(
    parameter int FILTER_COUNT = can_rx_accept_pkg::FILTER_COUNT,
    parameter int BUF_BYTES = can_rx_accept_pkg::BUF_BYTES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic configMode,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic frameValid,
    input wire logic frameExt,
    input wire logic frameRtr,
    input wire logic [10:0] frameStdId,
    input wire logic [17:0] frameExtId,
    input wire logic [3:0] frameDlc,
    input wire logic [63:0] frameData,
    output logic rx0Loaded,
    output logic rx1Loaded,
    output logic [2:0] matchedFilterCode
);
    localparam int IDW = can_rx_accept_pkg::ID_WIDTH;

    logic [7:0] filterReg [0:FILTER_COUNT-1][0:3];
    logic [7:0] maskReg [0:can_rx_accept_pkg::MASK_COUNT-1][0:3];
    logic [7:0] bufReg [0:1][0:BUF_BYTES-1];
    logic [FILTER_COUNT-1:0] hits;
    logic [7:0] regRdData_next;
    logic [2:0] hitCode;
    logic hitAny;
    logic hitBuf;
    logic [7:0] frameBytes [0:BUF_BYTES-1];
    logic [FILTER_COUNT-1:0] filterSel;
    logic [can_rx_accept_pkg::MASK_COUNT-1:0] maskSel;
    logic [1:0] bufSel;
    logic inImage;

    function automatic logic [7:0] filterBase(input int f);
        if (f < 3) begin
            filterBase = can_rx_accept_pkg::FILTER0_BASE + 8'(f * 4);
        end else begin
            filterBase = can_rx_accept_pkg::FILTER3_BASE + 8'((f - 3) * 4);
        end
    endfunction : filterBase

    genvar g;
    generate
        for (g = 0; g < FILTER_COUNT; g++) begin : gFilt
            localparam int M = (g < 2) ? 0 : 1;
            can_filter_match #(.ID_WIDTH(IDW)) uMatch (
                .maskBits({maskReg[M][0], maskReg[M][1][7:5], maskReg[M][1][1:0], maskReg[M][2], maskReg[M][3]}),
                .filterBits({filterReg[g][0], filterReg[g][1][7:5], filterReg[g][1][1:0],
                    filterReg[g][2], filterReg[g][3]}),
                .extEnable(filterReg[g][1][can_rx_accept_pkg::EXT_ENABLE_BIT]),
                .frameExt(frameExt),
                .frameRtr(frameRtr),
                .frameStdId(frameStdId),
                .frameExtId(frameExtId),
                .frameData0(frameData[63:56]),
                .frameData1(frameData[55:48]),
                .hit(hits[g])
            );
        end
    endgenerate

    always_comb begin
        hitCode = 3'h0;
        hitAny = 1'b0;
        for (int f = FILTER_COUNT - 1; f >= 0; f--) begin
            if (hits[f]) begin
                hitCode = 3'(f);
                hitAny = 1'b1;
            end
        end
        hitBuf = (hitCode >= 3'h2);
    end

    // Frame laid out as a receive buffer image
    always_comb begin
        for (int k = 0; k < BUF_BYTES; k++) begin
            frameBytes[k] = can_rx_accept_pkg::RESET_BYTE;
        end
        frameBytes[can_rx_accept_pkg::CTRL_POS] = {5'h00, hitCode};
        frameBytes[can_rx_accept_pkg::BUF_STD_HIGH_POS] = frameStdId[10:3];
        frameBytes[can_rx_accept_pkg::BUF_STD_LOW_POS] = {frameStdId[2:0], frameRtr & ~frameExt, frameExt,
            1'b0, frameExtId[17:16]};
        frameBytes[can_rx_accept_pkg::BUF_EXT_HIGH_POS] = frameExtId[15:8];
        frameBytes[can_rx_accept_pkg::BUF_EXT_LOW_POS] = frameExtId[7:0];
        frameBytes[can_rx_accept_pkg::LENGTH_POS] = {1'b0, frameRtr & frameExt, 2'b00, frameDlc};
        for (int k = 0; k < 8; k++) begin
            frameBytes[can_rx_accept_pkg::DATA_POS + k] = frameData[63 - 8 * k -: 8];
        end
    end

    // A new frame overwrites its buffer, as there is no full flag
    // Store accepted frames
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int k = 0; k < BUF_BYTES; k++) begin
                    bufReg[b][k] <= can_rx_accept_pkg::RESET_BYTE;
                end
            end
        end else if (frameValid && hitAny) begin
            for (int k = 0; k < BUF_BYTES; k++) begin
                bufReg[hitBuf][k] <= frameBytes[k];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx0Loaded <= 1'b0;
            rx1Loaded <= 1'b0;
            matchedFilterCode <= 3'h0;
        end else begin
            rx0Loaded <= frameValid && hitAny && !hitBuf;
            rx1Loaded <= frameValid && hitAny && hitBuf;
            if (frameValid && hitAny) begin
                matchedFilterCode <= hitCode;
            end
        end
    end

    // Shared address decode; a filter or mask group spans four bytes
    always_comb begin
        for (int f = 0; f < FILTER_COUNT; f++) begin
            filterSel[f] = (regAddr[7:2] == 6'(filterBase(f) >> 2));
        end
        for (int m = 0; m < can_rx_accept_pkg::MASK_COUNT; m++) begin
            maskSel[m] = (regAddr[7:2] == 6'((can_rx_accept_pkg::MASK_BASE + 8'(m * 4)) >> 2));
        end
        // Bytes past the buffer image answer zero instead of aliasing
        inImage = (regAddr[3:0] < 4'(BUF_BYTES));
        bufSel[0] = inImage && (regAddr[7:4] == can_rx_accept_pkg::RX0_BASE[7:4]);
        bufSel[1] = inImage && (regAddr[7:4] == can_rx_accept_pkg::RX1_BASE[7:4]);
    end

    // Buffer addresses never reach the write decode, so buffers stay read-only
    // Writes gated by configuration mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int f = 0; f < FILTER_COUNT; f++) begin
                for (int k = 0; k < 4; k++) begin
                    filterReg[f][k] <= can_rx_accept_pkg::RESET_BYTE;
                end
            end
            for (int m = 0; m < can_rx_accept_pkg::MASK_COUNT; m++) begin
                for (int k = 0; k < 4; k++) begin
                    maskReg[m][k] <= can_rx_accept_pkg::RESET_BYTE;
                end
            end
        end else if (regWrite && configMode) begin
            for (int f = 0; f < FILTER_COUNT; f++) begin
                if (filterSel[f]) begin
                    filterReg[f][regAddr[1:0]] <= (regAddr[1:0] == can_rx_accept_pkg::ID_LOW_POS) ?
                        (regWrData & can_rx_accept_pkg::FILTER_LOW_WRMASK) : regWrData;
                end
            end
            for (int m = 0; m < can_rx_accept_pkg::MASK_COUNT; m++) begin
                if (maskSel[m]) begin
                    maskReg[m][regAddr[1:0]] <= (regAddr[1:0] == can_rx_accept_pkg::ID_LOW_POS) ?
                        (regWrData & can_rx_accept_pkg::MASK_LOW_WRMASK) : regWrData;
                end
            end
        end
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        regRdData_next = can_rx_accept_pkg::RESET_BYTE;
        for (int f = 0; f < FILTER_COUNT; f++) begin
            if (filterSel[f]) begin
                regRdData_next = filterReg[f][regAddr[1:0]];
            end
        end
        for (int m = 0; m < can_rx_accept_pkg::MASK_COUNT; m++) begin
            if (maskSel[m]) begin
                regRdData_next = maskReg[m][regAddr[1:0]];
            end
        end
        if (bufSel[0]) begin
            regRdData_next = bufReg[0][regAddr[3:0]];
        end else if (bufSel[1]) begin
            regRdData_next = bufReg[1][regAddr[3:0]];
        end
    end

    // Read data held until the next read so the port sees a stable byte
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= can_rx_accept_pkg::RESET_BYTE;
        end else if (regRead) begin
            regRdData <= regRdData_next;
        end
    end
endmodule : can_rx_acceptance_filter

// ===== core/can_rx_accept_pkg.sv
// Constants shared by the receive acceptance filter design.
// Assumes a byte-wide register port with 8-bit addresses.
package can_rx_accept_pkg;
    localparam int ID_WIDTH = 29;
    localparam int FILTER_COUNT = 6;
    localparam int MASK_COUNT = 2;
    localparam int BUF_BYTES = 14;
    // Filter and mask register bases
    localparam logic [7:0] FILTER0_BASE = 8'h00;
    localparam logic [7:0] FILTER3_BASE = 8'h10;
    localparam logic [7:0] MASK_BASE = 8'h20;
    localparam logic [7:0] FILTER_STRIDE = 8'h04;
    // Byte positions inside a filter or mask group
    localparam logic [1:0] ID_HIGH_POS = 2'h0;
    localparam logic [1:0] ID_LOW_POS = 2'h1;
    localparam logic [1:0] EXT_HIGH_POS = 2'h2;
    localparam logic [1:0] EXT_LOW_POS = 2'h3;
    localparam logic [7:0] FILTER_LOW_WRMASK = 8'heb;
    localparam logic [7:0] MASK_LOW_WRMASK = 8'he3;
    localparam int EXT_ENABLE_BIT = 3;
    // Receive buffers
    localparam logic [7:0] RX0_BASE = 8'h60;
    localparam logic [7:0] RX1_BASE = 8'h70;
    localparam logic [7:0] RX0_EXT_ID_HIGH = 8'h63;
    localparam logic [7:0] RX0_LENGTH_CODE = 8'h65;
    localparam logic [7:0] RX1_EXT_ID_HIGH = 8'h73;
    localparam logic [7:0] RX1_LENGTH_CODE = 8'h75;
    localparam logic [3:0] CTRL_POS = 4'h0;
    localparam logic [3:0] BUF_STD_HIGH_POS = 4'h1;
    localparam logic [3:0] BUF_STD_LOW_POS = 4'h2;
    localparam logic [3:0] BUF_EXT_HIGH_POS = 4'h3;
    localparam logic [3:0] BUF_EXT_LOW_POS = 4'h4;
    localparam logic [3:0] LENGTH_POS = 4'h5;
    localparam logic [3:0] DATA_POS = 4'h6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : can_rx_accept_pkg

// ===== core/can_filter_match.sv
// One acceptance filter compared against the assembled frame.
// Assumes frame fields are stable while frameValid is high.
`timescale 1ns/10ps
module can_filter_match #(
    parameter int ID_WIDTH = 29
) (
    input wire logic [ID_WIDTH-1:0] maskBits,
    input wire logic [ID_WIDTH-1:0] filterBits,
    input wire logic extEnable,
    input wire logic frameExt,
    input wire logic frameRtr,
    input wire logic [10:0] frameStdId,
    input wire logic [17:0] frameExtId,
    input wire logic [7:0] frameData0,
    input wire logic [7:0] frameData1,
    output logic hit
);
    logic [ID_WIDTH-1:0] compId;
    logic [ID_WIDTH-1:0] care;
    always_comb begin
        if (frameExt) begin
            compId = {frameStdId, frameExtId};
            care = maskBits;
        end else begin
            compId = {frameStdId, 2'b00, frameData0, frameData1};
            care = maskBits & {11'h7ff, 2'b00, {16{~frameRtr}}};
        end
        hit = (extEnable == frameExt) && (((compId ^ filterBits) & care) == '0);
    end
endmodule : can_filter_match

// ===== bench/can_rx_accept_assertions.sv
// Port checker for the receive acceptance filter.
// Assumes it is bound to can_rx_acceptance_filter on its one clock.
`timescale 1ns/10ps
module can_rx_accept_assertions #(
    parameter int FILTER_COUNT = 6
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdData,
    input wire logic frameValid,
    input wire logic rx0Loaded,
    input wire logic rx1Loaded,
    input wire logic [2:0] matchedFilterCode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic anyLoad = rx0Loaded | rx1Loaded;
    a_load_after_frame: assert property (anyLoad |-> $past(frameValid))
        else $error("load without frame");
    a_single_buffer: assert property (!(rx0Loaded && rx1Loaded))
        else $error("both buffers loaded");
    a_first_buffer_code: assert property (rx0Loaded |-> matchedFilterCode < 3'h2)
        else $error("bad code for buffer 0");
    a_second_buffer_code: assert property (rx1Loaded |-> matchedFilterCode > 3'h1 && matchedFilterCode < FILTER_COUNT)
        else $error("bad code for buffer 1");
    a_code_holds: assert property (!anyLoad |-> $stable(matchedFilterCode))
        else $error("code moved without load");
    a_length_form: assert property (regRead && regAddr[3:0] == 4'h5 && regAddr[7:5] == 3'h3 |=> (regRdData & 8'hb0) == 8'h00)
        else $error("length byte form");
    a_filter_low_form: assert property (regRead && regAddr == 8'h01 |=> (regRdData & 8'h14) == 8'h00)
        else $error("filter low byte form");
    a_mask_low_form: assert property (regRead && regAddr == 8'h21 |=> (regRdData & 8'h1c) == 8'h00)
        else $error("mask low byte form");
    a_read_holds: assert property (!regRead |=> $stable(regRdData))
        else $error("read data moved");
    c_first: cover property (rx0Loaded);
    c_second: cover property (rx1Loaded);
    c_back_to_back: cover property (anyLoad ##1 anyLoad);
endmodule : can_rx_accept_assertions
bind can_rx_acceptance_filter can_rx_accept_assertions #(.FILTER_COUNT(FILTER_COUNT)) u_check (
    .clock(clock), .rst_n(rst_n), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
    .frameValid(frameValid), .rx0Loaded(rx0Loaded), .rx1Loaded(rx1Loaded), .matchedFilterCode(matchedFilterCode));

// ===== bench/can_frame_source.sv
// Model of the assembly side that hands over received frames.
// Assumes one bench process calls send and idle.
`timescale 1ns/10ps
module can_frame_source (
    input wire logic clock,
    output logic frameValid,
    output logic frameExt,
    output logic frameRtr,
    output logic [10:0] frameStdId,
    output logic [17:0] frameExtId,
    output logic [3:0] frameDlc,
    output logic [63:0] frameData
);
    logic [98:0] f = '0;
    logic v = 1'b0;
    assign {frameExt, frameRtr, frameStdId, frameExtId, frameDlc, frameData} = f;
    assign frameValid = v;
    task automatic send(input logic e, r, input logic [10:0] s, input logic [17:0] x, input logic [3:0] d,
        input logic [63:0] b);
        @(negedge clock);
        {v, f} = {1'b1, e, r, s, x, d, b};
    endtask : send
    // Fields turn to junk between frames so stale ones never look valid
    task automatic idle();
        @(negedge clock);
        {v, f} = {1'b0, ~f};
    endtask : idle
endmodule : can_frame_source

// ===== bench/can_rx_acceptance_filter_bench.sv
// Self-checking bench for the receive acceptance filter.
// Assumes the frame source model and the bound checker.
`timescale 1ns/10ps
module can_rx_acceptance_filter_bench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic configMode = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic readTaken = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic frameValid, frameExt, frameRtr, rx0Loaded, rx1Loaded;
    logic [10:0] frameStdId;
    logic [17:0] frameExtId;
    logic [3:0] frameDlc;
    logic [63:0] frameData;
    logic [2:0] matchedFilterCode;
    logic [28:0] filt [6];
    logic [28:0] mask [2];
    logic filtExt [6];
    logic [7:0] bufLen [2];
    logic [11:0] expQ [$];
    logic [11:0] obs, expNote;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    integer seed = 32'h8e7b9c4e;
    always #25 clock = ~clock;
    can_frame_source u_source (.clock(clock), .frameValid(frameValid), .frameExt(frameExt), .frameRtr(frameRtr),
        .frameStdId(frameStdId), .frameExtId(frameExtId), .frameDlc(frameDlc), .frameData(frameData));
    can_rx_acceptance_filter u_dut (.clock(clock), .rst_n(rst_n), .configMode(configMode), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .frameValid(frameValid),
        .frameExt(frameExt), .frameRtr(frameRtr), .frameStdId(frameStdId), .frameExtId(frameExtId),
        .frameDlc(frameDlc),
        .frameData(frameData), .rx0Loaded(rx0Loaded), .rx1Loaded(rx1Loaded), .matchedFilterCode(matchedFilterCode));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {regWrite, regAddr, regWrData} = {1'b1, a, d};
        @(negedge clock);
        regWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        {regRead, regAddr} = {1'b1, a};
        expQ.push_back({4'h8, e});
        @(negedge clock);
        regRead = 1'b0;
    endtask : rd
    // Shadow follows only writes made in configuration mode
    task automatic set_group(input int g, input logic [28:0] v, input logic x, input logic on);
        logic [7:0] b;
        b = g > 5 ? 8'(4 * g + 8) : 8'(4 * g + (g > 2 ? 4 : 0));
        configMode = on;
        wr(b, v[28:21]);
        wr(b + 8'h1, {v[20:18], 1'b0, x, 1'b0, v[17:16]});
        wr(b + 8'h2, v[15:8]);
        wr(b + 8'h3, v[7:0]);
        if (on && g > 5) mask[g - 6] = v;
        if (on && g < 6) {filt[g], filtExt[g]} = {v, x};
    endtask : set_group
    function automatic logic [3:0] expect_hit(logic e, r, logic [28:0] id, logic [15:0] d);
        logic [28:0] cmp, cmpOn;
        cmp = e ? id : {id[28:18], 2'b00, d};
        cmpOn = e ? '1 : (r ? {11'h7ff, 18'h0} : {11'h7ff, 2'b00, 16'hffff});
        for (int i = 0; i < 6; i++)
            if (filtExt[i] == e && ((cmp ^ filt[i]) & mask[i > 1] & cmpOn) == '0) return {1'b1, 3'(i)};
        return 4'h0;
    endfunction : expect_hit
    task automatic final_report();
        if (expQ.size() != 0) fails++;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    always @(posedge clock) readTaken <= regRead;
    always @(negedge clock) begin
        if (readTaken || rx0Loaded || rx1Loaded) begin
            obs = readTaken ? {4'h8, regRdData} : {7'h00, rx1Loaded, rx0Loaded, matchedFilterCode};
            expNote = expQ.size() ? expQ.pop_front() : 12'hfff;
            n_compared++;
            if (expNote !== obs) begin
                fails++;
                $display("BAD t=%0t exp=%h got=%h", $time, expNote, obs);
            end
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        logic [28:0] id;
        logic [63:0] data;
        logic [3:0] hit, dlc;
        logic ext, rtr;
        int k, j;
        logic [7:0] rxBase;
        filt = '{default: '0};
        mask = '{default: '0};
        filtExt = '{default: 1'b0};
        bufLen = '{default: 8'h00};
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        wr(8'h63, 8'h5a);
        rd(8'h63, 8'h00);
        rd(8'h75, 8'h00);
        rd(8'h40, 8'h00);
        $display("test reset and read-only done");
        for (int r = 0; r < 10; r++) begin
            for (int g = 0; g < 8; g++)
                set_group(g, 29'($random(seed)) & (g > 5 ? 29'($random(seed)) : '1), 1'($random(seed)),
                    $random(seed) % 4 != 0);
            configMode = 1'b0;
            rd(8'h01, {filt[0][20:18], 1'b0, filtExt[0], 1'b0, filt[0][17:16]});
            rd(8'h21, {mask[0][20:18], 3'b000, mask[0][17:16]});
            for (int f = 0; f < 30; f++) begin
                k = {$random(seed)} % 6;
                id = filt[k] ^ (f % 3 == 0 ? 29'($random(seed)) : 29'h0);
                ext = f % 5 == 4 ? ~filtExt[k] : filtExt[k];
                rtr = 1'($random(seed));
                dlc = 4'($random(seed));
                data = {id[15:0], 48'($random(seed))};
                u_source.send(ext, rtr, id[28:18], id[17:0], dlc, data);
                hit = expect_hit(ext, rtr, id, data[63:48]);
                if (hit[3]) begin
                    expQ.push_back({7'h00, hit[2:0] > 3'h1, hit[2:0] < 3'h2, hit[2:0]});
                    bufLen[hit[2:0] > 3'h1] = {1'b0, rtr & ext, 2'b00, dlc};
                end
                // Every fourth frame runs straight into the next one
                if (f % 4 != 3) begin
                    u_source.idle();
                    rd(8'h65, bufLen[0]);
                    rd(8'h75, bufLen[1]);
                    if (hit[3]) begin
                        rxBase = hit[2:0] > 3'h1 ? 8'h70 : 8'h60;
                        j = {$random(seed)} % 8;
                        rd(rxBase + 8'h3, id[15:8]);
                        rd(rxBase + 8'h4, id[7:0]);
                        rd(rxBase + 8'(6 + j), data[63 - 8 * j -: 8]);
                    end
                end
            end
            u_source.idle();
            $display("test round %0d done", r);
        end
        final_report();
    end
endmodule : can_rx_acceptance_filter_bench
